// [pkg/omc_regs.svh]
// Constants for the output macrocell fabric: counts, widths, bit positions, reset values
`ifndef OMC_REGS_SVH
`define OMC_REGS_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define OMC_NUM_CELLS       8
`define OMC_TERMS_PER_CELL  9
`define OMC_LOGIC_TERMS     8
`define OMC_TOTAL_TERMS     72
`define OMC_DIR_TERM_IDX    8
`define OMC_IN_WIDTH        10

// ----------------------------------------------------------------------------
// Register map (Avalon-MM word addresses, byte address = 4 * index)
// ----------------------------------------------------------------------------
`define OMC_ADDR_WIDTH      4
`define OMC_IDX_ARCH_A      4'h0
`define OMC_IDX_ARCH_B      4'h1
`define OMC_IDX_POLARITY    4'h2
`define OMC_IDX_GLOBAL      4'h3
`define OMC_IDX_SECURITY    4'h4
`define OMC_IDX_STATUS      4'h5
`define OMC_IDX_PT_SELECT   4'h6
`define OMC_IDX_PT_DATA     4'h7
`define OMC_IDX_SPECIAL_PT  4'h8
`define OMC_IDX_CELL_REGS   4'h9

// ----------------------------------------------------------------------------
// Field positions and reset values (a set bit means "programmed")
// ----------------------------------------------------------------------------
`define OMC_GLOBAL_CFG_BIT  0
`define OMC_SEC_BIT         0
`define OMC_ARCH_RST        8'h00
`define OMC_POL_RST         8'h00
`define OMC_GLOBAL_RST      1'b0
`define OMC_PT_RST          20'h00000
`define OMC_READ_BLOCKED    32'h00000000
`define OMC_UNMAPPED_READ   32'h00000000

`endif

// [pkg/omc_pkg.sv]
// Types shared by the output macrocell fabric
package omc_pkg;

    // Four macrocell configurations, decoded from the two architecture bits
    typedef enum logic [1:0]
    {
        OMC_MODE_BIDIR,
        OMC_MODE_INPUT,
        OMC_MODE_OUTPUT,
        OMC_MODE_REGISTERED
    } omc_mode_t;

    // Bus slave state
    typedef enum logic
    {
        OMC_BUS_IDLE,
        OMC_BUS_DONE
    } omc_bus_t;

endpackage : omc_pkg

// [hdl/omc_fabric.sv]
// Output macrocell fabric: eight configurable macrocells with an Avalon-MM configuration port
//
// Function
// - Eight macrocells, each configured independently
// - 72 terms in eight groups of nine
// - Eight logic terms, ninth drives direction
// - Extra terms: synchronous preset, asynchronous reset
// - Two architecture bits pick four modes
// - Polarity bit inverts or passes output
// - Global bit programmed: clock and enable pins
// - Global bit clear: both pins plain inputs
// - Registered cells share shared enable pin
// - Bidirectional cells use own direction term
// - Global bit programmed iff any registered
// - Global bit L means clock/enable, H inputs
// - Both bits registered, B input, A output
// - Neither bit set: bidirectional, array tristate
// - Fixed output mode disables pin feedback
// - Unprogrammed AND gates evaluate low
// - Unprogrammed polarity is inverting
// - Unprogrammed cells bidirectional, driver disabled
// - Security bit blocks configuration readback
// - Registered cell captures into D flip-flop, feeds back
// - Registers cleared at power-up
//
// Chosen here: the Avalon-MM register port and the register addresses.
module omc_fabric
    import omc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic [9:0]  pinIn,
    input  wire logic [7:0]  cellPinIn,
    output logic [7:0]       cellPinOut,
    output logic [7:0]       cellPinOe,
    output logic [7:0]       feedback,
    output logic [71:0]      productTerms
);
`include "omc_regs.svh"

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    // Term masks live in an array; the struct carries the rest of the state
    typedef struct packed
    {
        omc_bus_t    bus;
        logic [31:0] rdata;
        logic [7:0]  archA;
        logic [7:0]  archB;
        logic [7:0]  polarity;
        logic        globalCfg;
        logic        security;
        logic [6:0]  ptSel;
        logic [1:0]  specialPt;
        logic [9:0]  pinMeta;
        logic [9:0]  pinSync;
        logic [7:0]  cellMeta;
        logic [7:0]  cellSync;
        logic        clkPrev;
        logic [7:0]  cellQ;
    } omc_state_t;

    omc_state_t  state_reg;
    omc_state_t  state_next;
    // One AND mask per term: bits 0..9 true inputs, bits 10..17 feedback, 18 unused, 19 programmed
    logic [19:0] ptMask_reg [0:73];

    // ------------------------------------------------------------------------
    // Array evaluation
    // ------------------------------------------------------------------------
    logic [7:0]  mode_reg_cell;
    logic        clkEnable;
    logic        sharedOe;
    logic        clkRise;
    logic [17:0] arrayIn;
    logic [73:0] termVal;
    logic [7:0]  sumTerm;
    logic        presetTerm;
    logic        asyncClr;

    // Shared pins only reach the macrocells as clock/enable when globally programmed
    assign clkEnable  = state_reg.globalCfg;
    assign sharedOe   = state_reg.globalCfg & state_reg.pinSync[9];
    assign clkRise    = clkEnable & state_reg.pinSync[0] & ~state_reg.clkPrev;
    // Unprogrammed global bit leaves pins 0 and 9 in the array as plain inputs
    assign arrayIn    = {feedback, state_reg.pinSync};

    genvar t;
    generate
        for (t = 0; t < 74; t = t + 1)
        begin : g_term
            // An unprogrammed term is forced low; a programmed one ANDs its selected inputs
            assign termVal[t] = ptMask_reg[t][19] & (&(arrayIn | ~ptMask_reg[t][17:0]));
        end
    endgenerate

    assign productTerms = termVal[71:0];
    assign presetTerm   = termVal[72];
    assign asyncClr     = termVal[73];

    genvar c;
    generate
        for (c = 0; c < 8; c = c + 1)
        begin : g_cell
            omc_mode_t mode;
            logic      logicOut;
            // Mode decode from the cell's own pair of bits
            always_comb
            begin
                case ({state_reg.archA[c], state_reg.archB[c]})
                    2'b11:   mode = OMC_MODE_REGISTERED;
                    2'b01:   mode = OMC_MODE_INPUT;
                    2'b10:   mode = OMC_MODE_OUTPUT;
                    default: mode = OMC_MODE_BIDIR;
                endcase
            end
            assign mode_reg_cell[c] = (mode == OMC_MODE_REGISTERED);
            // Eight logic terms sum; polarity bit clear means inverting
            assign sumTerm[c]  = |termVal[c*9 +: 8];
            assign logicOut    = state_reg.polarity[c] ? sumTerm[c] : ~sumTerm[c];
            // Registered cells drive the flop output; others drive logic directly
            assign cellPinOut[c] = mode_reg_cell[c] ?
                (state_reg.polarity[c] ? state_reg.cellQ[c] : ~state_reg.cellQ[c]) : logicOut;
            // Output enables: shared pin for registered, own term for bidirectional
            always_comb
            begin
                case (mode)
                    OMC_MODE_REGISTERED: cellPinOe[c] = sharedOe;
                    OMC_MODE_BIDIR:      cellPinOe[c] = termVal[c*9 + 8];
                    OMC_MODE_OUTPUT:     cellPinOe[c] = 1'b1;
                    default:             cellPinOe[c] = 1'b0;
                endcase
            end
            // Feedback: flop for registered, none for fixed output, pin otherwise
            always_comb
            begin
                case (mode)
                    OMC_MODE_REGISTERED: feedback[c] = state_reg.cellQ[c];
                    OMC_MODE_OUTPUT:     feedback[c] = 1'b0;
                    default:             feedback[c] = state_reg.cellSync[c];
                endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    logic        access;
    logic [31:0] rdNext;

    assign access = (read | write) & (state_reg.bus == OMC_BUS_IDLE);

    // Read mux; array contents are hidden once security is set
    always_comb
    begin
        rdNext = `OMC_UNMAPPED_READ;
        case (address)
            `OMC_IDX_ARCH_A:    rdNext = state_reg.security ? `OMC_READ_BLOCKED : {24'h000000, state_reg.archA};
            `OMC_IDX_ARCH_B:    rdNext = state_reg.security ? `OMC_READ_BLOCKED : {24'h000000, state_reg.archB};
            `OMC_IDX_POLARITY:  rdNext = state_reg.security ? `OMC_READ_BLOCKED : {24'h000000, state_reg.polarity};
            `OMC_IDX_GLOBAL:    rdNext = {31'h00000000, ~state_reg.globalCfg}; // L = programmed
            `OMC_IDX_SECURITY:  rdNext = {31'h00000000, state_reg.security};
            `OMC_IDX_STATUS:    rdNext = {16'h0000, mode_reg_cell, 5'h00, clkEnable, sharedOe, |mode_reg_cell};
            `OMC_IDX_PT_SELECT: rdNext = {25'h0000000, state_reg.ptSel};
            `OMC_IDX_PT_DATA:   rdNext = (state_reg.security || state_reg.ptSel > 7'd73) ? `OMC_READ_BLOCKED :
                                         {12'h000, ptMask_reg[state_reg.ptSel]};
            `OMC_IDX_SPECIAL_PT: rdNext = {30'h00000000, asyncClr, presetTerm};
            `OMC_IDX_CELL_REGS: rdNext = {24'h000000, state_reg.cellQ};
            default:            rdNext = `OMC_UNMAPPED_READ;
        endcase
    end

    always_comb
    begin
        state_next = state_reg;
        // Pins come from outside the clock domain: two flops before use
        state_next.pinMeta  = pinIn;
        state_next.pinSync  = state_reg.pinMeta;
        state_next.cellMeta = cellPinIn;
        state_next.cellSync = state_reg.cellMeta;
        state_next.clkPrev  = state_reg.pinSync[0];
        // Bus slave: one wait cycle, answer on the second
        case (state_reg.bus)
            OMC_BUS_IDLE:
            begin
                if (access)
                begin
                    state_next.bus   = OMC_BUS_DONE;
                    state_next.rdata = rdNext;
                end
            end
            OMC_BUS_DONE:
            begin
                state_next.bus = OMC_BUS_IDLE;
                if (write && !state_reg.security)
                begin
                    case (address)
                        `OMC_IDX_ARCH_A:    state_next.archA    = writedata[7:0];
                        `OMC_IDX_ARCH_B:    state_next.archB    = writedata[7:0];
                        `OMC_IDX_POLARITY:  state_next.polarity = writedata[7:0];
                        `OMC_IDX_PT_SELECT: state_next.ptSel    = writedata[6:0];
                        default:            state_next.ptSel    = state_reg.ptSel;
                    endcase
                end
                // Security is one-way until reset
                if (write && address == `OMC_IDX_SECURITY && writedata[`OMC_SEC_BIT])
                    state_next.security = 1'b1;
            end
            default: state_next.bus = OMC_BUS_IDLE;
        endcase
        // Global bit follows the architecture: programmed iff any cell registered
        state_next.globalCfg = |(state_next.archA & state_next.archB);
        // Registered cells: sync preset on shared-clock rising edge, async clear wins
        for (int i = 0; i < 8; i++)
        begin
            if (mode_reg_cell[i] && clkRise)
                state_next.cellQ[i] = presetTerm ? 1'b1 : sumTerm[i];
        end
        if (asyncClr)
            state_next.cellQ = 8'h00;
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Power-up reset clears the flops and leaves the fabric in its blank state
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg          <= '0;
            state_reg.bus      <= OMC_BUS_IDLE;
            state_reg.archA    <= `OMC_ARCH_RST;
            state_reg.archB    <= `OMC_ARCH_RST;
            state_reg.polarity <= `OMC_POL_RST;
            state_reg.globalCfg <= `OMC_GLOBAL_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Term mask memory: written through the select/data pair
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int k = 0; k < 74; k++)
                ptMask_reg[k] <= `OMC_PT_RST;
        end
        else if (state_reg.bus == OMC_BUS_DONE && write && !state_reg.security &&
                 address == `OMC_IDX_PT_DATA && state_reg.ptSel <= 7'd73)
        begin
            ptMask_reg[state_reg.ptSel] <= writedata[19:0];
        end
    end

    assign waitrequest = (read | write) & (state_reg.bus != OMC_BUS_DONE);
    assign readdata    = state_reg.rdata;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_global_tracks_arch;
        @(posedge sys_clk) disable iff (!rstn)
        state_reg.globalCfg == |(state_reg.archA & state_reg.archB);
    endproperty
    a_global_tracks_arch: assert property (p_global_tracks_arch) else $error("global bit mismatch");

    property p_async_clear;
        @(posedge sys_clk) disable iff (!rstn)
        asyncClr |=> (state_reg.cellQ == 8'h00);
    endproperty
    a_async_clear: assert property (p_async_clear) else $error("async clear missed");

    property p_unprog_low;
        @(posedge sys_clk) disable iff (!rstn)
        !ptMask_reg[0][19] |-> !termVal[0];
    endproperty
    a_unprog_low: assert property (p_unprog_low) else $error("blank term high");

    property p_output_no_fb;
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg.archA[0] && !state_reg.archB[0]) |-> feedback[0] == 1'b0;
    endproperty
    a_output_no_fb: assert property (p_output_no_fb) else $error("feedback leaked");

    property p_reg_oe;
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg.archA[1] && state_reg.archB[1]) |-> cellPinOe[1] == sharedOe;
    endproperty
    a_reg_oe: assert property (p_reg_oe) else $error("registered enable wrong");

    property p_bidir_oe;
        @(posedge sys_clk) disable iff (!rstn)
        (!state_reg.archA[2] && !state_reg.archB[2]) |-> cellPinOe[2] == termVal[26];
    endproperty
    a_bidir_oe: assert property (p_bidir_oe) else $error("bidir enable wrong");

    sequence s_preset_edge;
        mode_reg_cell[3] && clkRise && presetTerm && !asyncClr;
    endsequence
    property p_preset;
        @(posedge sys_clk) disable iff (!rstn)
        s_preset_edge |=> state_reg.cellQ[3];
    endproperty
    a_preset: assert property (p_preset) else $error("preset missed");

    property p_security_read;
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg.security && access && address == `OMC_IDX_ARCH_A) |=> readdata == 32'h00000000;
    endproperty
    a_security_read: assert property (p_security_read) else $error("readback leaked");

    property p_noclk_hold;
        @(posedge sys_clk) disable iff (!rstn)
        (!clkEnable && !asyncClr) |=> $stable(state_reg.cellQ);
    endproperty
    a_noclk_hold: assert property (p_noclk_hold) else $error("flop moved without clock");

    // Per-mode pin and flop behaviour, on cells whose mode the bench sets; then shared pins and security
    property p_polarity;
        @(posedge sys_clk) disable iff (!rstn)
        !mode_reg_cell[4] |-> cellPinOut[4] == (state_reg.polarity[4] ~^ (|productTerms[36 +: 8]));
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity wrong");

    property p_dir_term;
        @(posedge sys_clk) disable iff (!rstn)
        (!state_reg.archA[0] && !state_reg.archB[0]) |-> cellPinOe[0] == productTerms[8];
    endproperty
    a_dir_term: assert property (p_dir_term) else $error("direction term ignored");

    property p_input_oe;
        @(posedge sys_clk) disable iff (!rstn)
        (!state_reg.archA[5] && state_reg.archB[5]) |-> !cellPinOe[5];
    endproperty
    a_input_oe: assert property (p_input_oe) else $error("input cell drives");

    property p_output_oe;
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg.archA[6] && !state_reg.archB[6]) |-> cellPinOe[6];
    endproperty
    a_output_oe: assert property (p_output_oe) else $error("output cell idle");

    sequence s_capture_edge;
        mode_reg_cell[3] && clkRise && !presetTerm && !asyncClr;
    endsequence
    property p_capture;
        @(posedge sys_clk) disable iff (!rstn)
        s_capture_edge |=> state_reg.cellQ[3] == $past(sumTerm[3]);
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");

    property p_no_reg_no_clk;
        @(posedge sys_clk) disable iff (!rstn)
        !(|mode_reg_cell) |-> (!clkEnable && !sharedOe);
    endproperty
    a_no_reg_no_clk: assert property (p_no_reg_no_clk) else $error("shared pins not plain inputs");

    property p_sec_sticky;
        @(posedge sys_clk) disable iff (!rstn)
        state_reg.security |=> state_reg.security;
    endproperty
    a_sec_sticky: assert property (p_sec_sticky) else $error("security dropped");

    property p_sec_write_block;
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg.security && state_reg.bus == OMC_BUS_DONE && write) |=>
            $stable({state_reg.archA, state_reg.archB, state_reg.polarity});
    endproperty
    a_sec_write_block: assert property (p_sec_write_block) else $error("locked setup changed");

endmodule : omc_fabric

// [tb/omc_board_model.sv]
// Board-side model: drives the dedicated inputs and resolves the macrocell pins
module omc_board_model
(
    input  wire logic [9:0] drvIn,
    input  wire logic [7:0] boardVal,
    input  wire logic [7:0] boardEn,
    input  wire logic [7:0] cellPinOut,
    input  wire logic [7:0] cellPinOe,
    output logic      [9:0] pinIn,
    output logic      [7:0] cellPinIn
);
    timeunit 1ns;
    timeprecision 1ps;

    // --------------------------------------------------------------------
    // Dedicated pins, shared clock and enable pins among them
    // --------------------------------------------------------------------
    assign pinIn = drvIn;

    // --------------------------------------------------------------------
    // Pin level
    // --------------------------------------------------------------------
    // The cell wins while it drives, then the board; an idle pin floats up
    // so that a stale value never passes for a driven one
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            cellPinIn[i] = cellPinOe[i] ? cellPinOut[i] : (boardEn[i] ? boardVal[i] : 1'b1);
    end
endmodule : omc_board_model

// [tb/omc_fabric_test.sv]
// Self-checking bench for the output macrocell fabric
`include "omc_regs.svh"
module omc_fabric_test;
    timeunit 1ns;
    timeprecision 1ps;

    // --------------------------------------------------------------------
    // Signals and reference state
    // --------------------------------------------------------------------
    logic        sysClk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  address = 4'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, q;
    logic        waitrequest;
    logic [9:0]  drvIn = 10'h000, pinIn;
    logic [7:0]  boardVal = 8'h00, boardEn = 8'h00, cellPinIn, cellPinOut, cellPinOe, feedback;
    logic [71:0] productTerms;
    int          nFail = 0, nTests = 0, seed = 84074, mSel = 0;
    logic [7:0]  mA = 8'h00, mB = 8'h00, mP = 8'h00;
    logic [19:0] mT [74];
    logic        mSec = 1'b0, mFlop = 1'b0;
    int          regs [8] = '{0, 1, 2, 3, 4, 5, 9, 15};

    always #5 sysClk = ~sysClk;

    omc_fabric dut (.sys_clk(sysClk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .pinIn(pinIn),
        .cellPinIn(cellPinIn), .cellPinOut(cellPinOut), .cellPinOe(cellPinOe), .feedback(feedback),
        .productTerms(productTerms));
    omc_board_model board (.drvIn(drvIn), .boardVal(boardVal), .boardEn(boardEn),
        .cellPinOut(cellPinOut), .cellPinOe(cellPinOe), .pinIn(pinIn), .cellPinIn(cellPinIn));

    // --------------------------------------------------------------------
    // Reference model
    // --------------------------------------------------------------------
    // A term is low unless programmed, then the AND of the inputs it uses
    function automatic logic term(input int t);
        return mT[t][19] & ((drvIn & mT[t][9:0]) == mT[t][9:0]);
    endfunction : term

    function automatic logic [31:0] expReg(input int a);
        logic [7:0] r;
        r = mA & mB;
        case (a)
            0: return mSec ? `OMC_READ_BLOCKED : {24'h0, mA};
            1: return mSec ? `OMC_READ_BLOCKED : {24'h0, mB};
            2: return mSec ? `OMC_READ_BLOCKED : {24'h0, mP};
            3: return {31'h0, ~|r};
            4: return {31'h0, mSec};
            5: return {16'h0, r, 5'h0, |r, 1'b0, |r};
            7: return mSec ? `OMC_READ_BLOCKED : {12'h0, mT[mSel]};
            9: return {28'h0, mFlop, 3'h0};
            default: return `OMC_UNMAPPED_READ;
        endcase
    endfunction : expReg

    // --------------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------------
    task automatic chk(input logic [71:0] got, input logic [71:0] exp, input string what);
        nTests++;
        if (got !== exp)
        begin
            nFail++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask : chk

    // One Avalon access; holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sysClk);
        address <= a;
        write <= wr;
        read <= ~wr;
        writedata <= d;
        // Settled value seen mid-cycle is the one the next rising edge samples
        do
        begin
            @(negedge sysClk);
            k++;
        end
        while (waitrequest !== 1'b0);
        @(posedge sysClk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        chk(k, 2, "bus answer");
    endtask : bus

    task automatic regCheck(input int a, input logic [31:0] m);
        bus(1'b0, a[3:0], 32'h0);
        chk(q & m, expReg(a) & m, "register read");
    endtask : regCheck

    task automatic setTerm(input int t, input logic [9:0] m, input logic on);
        bus(1'b1, `OMC_IDX_PT_SELECT, 32'(t));
        bus(1'b1, `OMC_IDX_PT_DATA, {12'h0, on, 9'h0, m});
        mT[t] = {on, 9'h0, m};
        mSel = t;
    endtask : setTerm

    // Lets the input synchronisers settle, then compares the pin results, of the registered cells only the enables and cell 3's pin
    task automatic settleCheck();
        logic [71:0] e;
        logic [7:0]  s;
        repeat (4) @(posedge sysClk);
        @(negedge sysClk);
        for (int t = 0; t < 72; t++)
            e[t] = term(t);
        chk(productTerms, e, "term values");
        for (int c = 0; c < 8; c++)
        begin
            s[c] = |e[9*c +: 8];
            if (!mB[c])
                chk(cellPinOut[c], {mP[c] ? s[c] : ~s[c]}, "pin value");
            if (!(mA[c] & mB[c]))
            begin
                chk(cellPinOe[c], mA[c] ? 1'b1 : (mB[c] ? 1'b0 : e[9*c+8]), "pin enable");
                chk(feedback[c], mA[c] ? 1'b0 : cellPinIn[c], "feedback");
            end
            else
            begin
                chk(cellPinOe[c], drvIn[9], "shared enable");
                if (c == 3)
                    chk(cellPinOut[c], {mP[c] ? mFlop : ~mFlop}, "flop pin");
            end
        end
    endtask : settleCheck

    task automatic pulse();
        @(posedge sysClk);
        drvIn[0] <= 1'b1;
        repeat (4) @(posedge sysClk);
        drvIn[0] <= 1'b0;
        repeat (4) @(posedge sysClk);
    endtask : pulse

    task automatic setArch();
        bus(1'b1, `OMC_IDX_ARCH_A, {24'h0, mA});
        bus(1'b1, `OMC_IDX_ARCH_B, {24'h0, mB});
        bus(1'b1, `OMC_IDX_POLARITY, {24'h0, mP});
        for (int i = 0; i < 6; i++)
            regCheck(regs[i], regs[i] == 5 ? 32'hff05 : 32'hffffffff);
    endtask : setArch

    task automatic endOfTest();
        $display("tests %0d mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : endOfTest

    // --------------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------------
    initial
    begin
        for (int t = 0; t < 74; t++)
            mT[t] = 20'h0;
        repeat (10) @(posedge sysClk);
        rstn <= 1'b1;
        // Blank part, including an unmapped place
        for (int i = 0; i < 8; i++)
            regCheck(regs[i], regs[i] == 5 ? 32'hff05 : 32'hffffffff);
        settleCheck();
        // Output and input cells among bidirectional ones, random polarity
        mA = 8'h44;
        mB = 8'h22;
        mP = 8'($random(seed));
        setArch();
        for (int c = 0; c < 8; c++)
        begin
            setTerm(9*c+8, 10'h000, c < 4);
            setTerm(9*c+c, 10'($random(seed)) & 10'h1fe, 1'b1);
        end
        for (int i = 0; i < 6; i++)
        begin
            @(posedge sysClk);
            drvIn <= 10'($random(seed));
            boardEn <= 8'($random(seed));
            boardVal <= 8'($random(seed));
            settleCheck();
        end
        // Registered cells enable clock and shared enable
        mA = 8'hcc;
        mB = 8'haa;
        setArch();
        settleCheck();
        // Flop of cell 3: capture, clear, preset
        @(posedge sysClk);
        drvIn <= drvIn & 10'h1fe;
        setTerm(30, 10'h000, 1'b1);
        regCheck(7, 32'hffffffff);
        pulse();
        mFlop = 1'b1;
        regCheck(9, 32'h8);
        setTerm(73, 10'h000, 1'b1);
        mFlop = 1'b0;
        regCheck(9, 32'h8);
        setTerm(72, 10'h000, 1'b1);
        pulse();
        regCheck(9, 32'h8);
        setTerm(73, 10'h000, 1'b0);
        setTerm(30, 10'h000, 1'b0);
        pulse();
        mFlop = 1'b1;
        regCheck(9, 32'h8);
        setTerm(72, 10'h000, 1'b0);
        pulse();
        mFlop = 1'b0;
        regCheck(9, 32'h8);
        // Locked part ignores changes and hides the setup
        bus(1'b1, `OMC_IDX_SECURITY, 32'h1);
        bus(1'b1, `OMC_IDX_ARCH_A, 32'h0);
        mSec = 1'b1;
        settleCheck();
        regCheck(0, 32'hffffffff);
        regCheck(7, 32'hffffffff);
        regCheck(15, 32'hffffffff);
        endOfTest();
    end

    // Watchdog, far beyond the few hundred cycles the sequence needs
    initial
    begin
        #500000;
        nFail++;
        endOfTest();
    end
endmodule : omc_fabric_test
